// ---- pkg/dram_read_throttle_params.svh ----
// Register offsets, field positions and reset values of the read throttle block
`ifndef DRAM_READ_THROTTLE_PARAMS_SVH
`define DRAM_READ_THROTTLE_PARAMS_SVH

`define DRT_CTRL_LO_OFS     8'hD8
`define DRT_CTRL_HI_OFS     8'hDC
`define DRT_STATUS_OFS      8'hE0
`define DRT_CTRL_RESET      64'h0000_0000_0000_0000
`define DRT_CTRL_W          41
`define DRT_THR_MSB         40
`define DRT_THR_LSB         28
`define DRT_THR_SHIFT       15
`define DRT_DUR_MSB         27
`define DRT_DUR_LSB         22
`define DRT_MWIN_MSB        21
`define DRT_MWIN_LSB        15
`define DRT_MWIN_SHIFT      4
`define DRT_MAX_MSB         14
`define DRT_MAX_LSB         3
`define DRT_SEL_MSB         2
`define DRT_SEL_LSB         1
`define DRT_GO_BIT          0

`endif

// ---- pkg/dram_read_throttle_pkg.sv ----
// Types shared by the read throttle block
package dram_read_throttle_pkg;
	typedef enum logic [1:0] {
		SEL_OFF     = 2'b00,
		SEL_RSVD1   = 2'b01,
		SEL_COUNTER = 2'b10,
		SEL_RSVD3   = 2'b11
	} read_throttle_select_t;
endpackage

// ---- core/dram_read_throttle.sv ----
// Counter based DRAM read throttle with its control register
`timescale 1ns/1ps
`default_nettype none
`include "dram_read_throttle_params.svh"

module dram_read_throttle
	import dram_read_throttle_pkg::*;
#(
	parameter int GSW_W = 32
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [7:0]       addr_in,
	input  wire logic [31:0]      wdata_in,
	input  wire logic             wr_in,
	input  wire logic             rd_in,
	output var  logic [31:0]      rdata_out,
	input  wire logic             rd_hexword_in,
	input  wire logic [GSW_W-1:0] global_read_sampling_window_in,
	output var  logic             read_block_out,
	output var  logic             throttle_active_out
);

	localparam int CNT_W = 13 + `DRT_THR_SHIFT;

	typedef struct packed {
		logic [`DRT_CTRL_W-1:0] ctrl;
		logic [31:0]            rdata;
		logic [GSW_W-1:0]       gwin_cnt;
		logic [CNT_W-1:0]       gread_cnt;
		logic [5:0]             dur_cnt;
		logic                   active;
		logic [10:0]            mwin_cnt;
		logic [11:0]            mread_cnt;
		logic                   block;
	} state_t;

	state_t r;
	state_t n;

	generate
		if (GSW_W < 1 || GSW_W > 32) begin : g_bad_width
			$error("GSW_W must lie between 1 and 32");
		end
	endgenerate

	function automatic logic [31:0] status_word(input state_t s);
		status_word = {4'h0, s.mread_cnt, 8'h00, s.dur_cnt, s.block, s.active};
	endfunction

	logic                  go;
	logic                  enabled;
	logic                  gend;
	logic [10:0]           mlen;
	logic                  mend;
	logic [CNT_W-1:0]      thr_val;
	logic [CNT_W-1:0]      gread_inc;
	logic [11:0]           mread_inc;
	logic [11:0]           max_val;
	logic [5:0]            dur_val;
	read_throttle_select_t sel;

	always_comb begin
		go        = r.ctrl[`DRT_GO_BIT];
		sel       = read_throttle_select_t'(r.ctrl[`DRT_SEL_MSB:`DRT_SEL_LSB]);
		enabled   = go && (sel == SEL_COUNTER);
		gend      = ({1'b0, r.gwin_cnt} + (GSW_W+1)'(1))
		            >= {1'b0, global_read_sampling_window_in};
		thr_val   = {r.ctrl[`DRT_THR_MSB:`DRT_THR_LSB], {`DRT_THR_SHIFT{1'b0}}};
		mlen      = {r.ctrl[`DRT_MWIN_MSB:`DRT_MWIN_LSB], {`DRT_MWIN_SHIFT{1'b0}}};
		mend      = (r.mwin_cnt == mlen - 11'd1);
		max_val   = r.ctrl[`DRT_MAX_MSB:`DRT_MAX_LSB];
		dur_val   = r.ctrl[`DRT_DUR_MSB:`DRT_DUR_LSB];
		gread_inc = (&r.gread_cnt) ? r.gread_cnt : r.gread_cnt + CNT_W'(rd_hexword_in);
		mread_inc = (&r.mread_cnt) ? r.mread_cnt : r.mread_cnt + 12'(rd_hexword_in);
	end

	always_comb begin
		n       = r;
		n.rdata = 32'h0000_0000;
		if (wr_in) begin
			if (addr_in == `DRT_CTRL_LO_OFS)
				n.ctrl[31:0] = wdata_in;
			else if (addr_in == `DRT_CTRL_HI_OFS)
				n.ctrl[`DRT_CTRL_W-1:32] = wdata_in[`DRT_CTRL_W-33:0];
		end
		if (rd_in) begin
			unique case (addr_in)
				`DRT_CTRL_LO_OFS: n.rdata = r.ctrl[31:0];
				`DRT_CTRL_HI_OFS: n.rdata = {{(64-`DRT_CTRL_W){1'b0}}, r.ctrl[`DRT_CTRL_W-1:32]};
				`DRT_STATUS_OFS:  n.rdata = status_word(r);
				default:          n.rdata = 32'h0000_0000;
			endcase
		end
		if (!enabled) begin
			// Stopped or off: all counters cleared
			n.gwin_cnt  = '0;
			n.gread_cnt = '0;
			n.dur_cnt   = 6'h00;
			n.active    = 1'b0;
			n.mwin_cnt  = 11'h000;
			n.mread_cnt = 12'h000;
			n.block     = 1'b0;
		end else begin
			// Global sampling window runs while enabled
			n.gwin_cnt  = gend ? '0 : r.gwin_cnt + GSW_W'(1);
			n.gread_cnt = gend ? '0 : gread_inc;
			if (!r.active) begin
				if (gread_inc >= thr_val && dur_val != 6'h00) begin
					n.active  = 1'b1;
					n.dur_cnt = dur_val;
				end
			end else if (gend) begin
				if (r.dur_cnt <= 6'h01) begin
					n.active  = 1'b0;
					n.dur_cnt = 6'h00;
				end else begin
					n.dur_cnt = r.dur_cnt - 6'h01;
				end
			end
			if (r.active && mlen != 11'h000) begin
				n.mwin_cnt  = mend ? 11'h000 : r.mwin_cnt + 11'h001;
				n.mread_cnt = mend ? 12'h000 : mread_inc;
			end else begin
				n.mwin_cnt  = 11'h000;
				n.mread_cnt = 12'h000;
			end
			n.block = n.active && (mlen != 11'h000) && (n.mread_cnt >= max_val);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r       <= '0;
			r.ctrl  <= `DRT_CTRL_W'(`DRT_CTRL_RESET);
		end else begin
			r <= n;
		end
	end

	always_comb begin
		rdata_out           = r.rdata;
		read_block_out      = r.block;
		throttle_active_out = r.active;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_THRESHOLD_INVOKES: assert property (
		enabled && !r.active && gread_inc >= thr_val && dur_val != 6'h00 |=> r.active
	) else $error("threshold reached but throttling not invoked");

	AST_DURATION_ENDS: assert property (
		enabled && r.active && gend && r.dur_cnt == 6'h01 |=> !r.active
	) else $error("throttling outlived its duration");

	AST_MONITOR_WRAPS: assert property (
		enabled && r.active && mlen != 11'h000 && mend |=> r.mwin_cnt == 11'h000
	) else $error("monitor window did not restart at its length");

	AST_BLOCK_ONLY_ACTIVE: assert property (
		r.block |-> r.active && $past(enabled)
	) else $error("reads blocked while throttling not invoked");

	AST_BLOCK_AT_MAX: assert property (
		r.block |-> r.mread_cnt >= $past(max_val)
	) else $error("reads blocked below the window maximum");

	AST_SELECT_OFF: assert property (
		r.ctrl[`DRT_SEL_MSB:`DRT_SEL_LSB] != 2'b10 |=> !r.active && !r.block
	) else $error("throttling active outside counter mode");

	AST_DURATION_STEPS: assert property (
		enabled && r.active && gend && r.dur_cnt > 6'h01
		|=> r.active && r.dur_cnt == $past(r.dur_cnt) - 6'h01
	) else $error("duration count did not step at window end");

	AST_GO_CLEAR: assert property (
		!r.ctrl[`DRT_GO_BIT] |=> !r.block && r.mwin_cnt == 11'h000 && r.mread_cnt == 12'h000
	) else $error("counters not cleared while stopped");

	AST_GO_SET: assert property (
		wr_in && addr_in == `DRT_CTRL_LO_OFS && wdata_in[`DRT_GO_BIT]
		|=> r.ctrl[`DRT_GO_BIT] && rdata_out == 32'h0000_0000 || $past(rd_in)
	) else $error("go bit not taken from write");

	AST_GLOBAL_RESTART: assert property (
		enabled && gend |=> r.gwin_cnt == '0 && r.gread_cnt == '0
	) else $error("global window did not restart at its length");

	AST_BLOCK_RELEASE: assert property (
		enabled && r.active && mlen != 11'h000 && mend && max_val != 12'h000 |=> !r.block
	) else $error("reads still blocked after monitor window end");

	AST_ZERO_DURATION: assert property (
		enabled && !r.active && dur_val == 6'h00 |=> !r.active
	) else $error("throttling invoked with zero duration");

	AST_MONITOR_COUNTS: assert property (
		enabled && r.active && mlen != 11'h000 && !mend && !(&r.mread_cnt)
		|=> r.mread_cnt == $past(r.mread_cnt) + 12'($past(rd_hexword_in))
	) else $error("monitor hexword count did not follow reads");

	AST_STOP_CLEARS_GLOBAL: assert property (
		!enabled |=> !r.active && r.gwin_cnt == '0 && r.gread_cnt == '0 && r.dur_cnt == 6'h00
	) else $error("global counters not cleared while stopped");

	AST_WINDOW_STEPS: assert property (
		enabled && r.active && mlen != 11'h000 && !mend
		|=> r.mwin_cnt == $past(r.mwin_cnt) + 11'h001
	) else $error("monitor window count did not step");

	AST_THRESHOLD_HOLDS_OFF: assert property (
		enabled && !r.active && gread_inc < thr_val |=> !r.active
	) else $error("throttling invoked below threshold");

endmodule // dram_read_throttle
`default_nettype wire

// ---- tb/read_path_model.sv ----
// Behavioural model of the DRAM read request path
`timescale 1ns/1ps
`default_nettype none
module read_path_model (
	input  wire logic clk_in,
	input  wire logic block_in,
	output var  logic hexword_out
);
	initial hexword_out = 1'b0;
	// Random read traffic, held off while blocked
	always @(posedge clk_in) begin
		hexword_out <= !block_in && ($urandom() % 4 != 0);
	end
endmodule // read_path_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the read throttle block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dram_read_throttle_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic        hexword;
	logic        read_block_out;
	logic        throttle_active_out;
	logic [63:0] v;
	logic [31:0] gsw = 32'h0000_03E8;
	logic [31:0] span;
	logic [31:0] gap;
	int          bad_count = 0;
	int          checked = 0;
	always #5 clk_in = ~clk_in;
	dram_read_throttle #(.GSW_W(32)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .rd_hexword_in(hexword),
		.global_read_sampling_window_in(gsw),
		.read_block_out(read_block_out), .throttle_active_out(throttle_active_out));
	read_path_model i_far (.clk_in(clk_in), .block_in(read_block_out), .hexword_out(hexword));
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		cmp("rdata_out", e, rdata_out);
	endtask
	task automatic await_block(input logic lvl);
		int k = 0;
		#1;
		while (read_block_out !== lvl && k < 40) begin
			@(posedge clk_in);
			#1;
			k++;
		end
		cmp("read_block_out", {31'h0000_0000, lvl}, {31'h0000_0000, read_block_out});
	endtask
	// Expected {block, active} with zero maximum
	function automatic logic [1:0] expect_out(input logic [63:0] c);
		logic act;
		act = c[0] && c[2:1] == SEL_COUNTER && c[40:28] == 13'h0000 && c[27:22] != 6'h00;
		return {act && c[21:15] != 7'h00, act};
	endfunction
	// Invocation lags the window start by one clock
	function automatic logic [31:0] expect_span(input int dur, input logic [31:0] len);
		return 32'(dur) * len - 32'h0000_0001;
	endfunction
	// Length of the first active span and of the idle gap after it
	task automatic measure_active(output logic [31:0] s, output logic [31:0] g);
		int k = 0;
		s = 32'h0000_0000;
		g = 32'h0000_0000;
		#1;
		while (throttle_active_out !== 1'b1 && k < 100) begin
			@(posedge clk_in);
			#1;
			k++;
		end
		while (throttle_active_out === 1'b1 && s < 32'h0000_0190) begin
			@(posedge clk_in);
			#1;
			s++;
		end
		while (throttle_active_out !== 1'b1 && g < 32'h0000_0010) begin
			@(posedge clk_in);
			#1;
			g++;
		end
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h0000_02CF));
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(8'hD8, 32'h0000_0000);
		rd(8'hDC, 32'h0000_0000);
		v = {$urandom(), $urandom()};
		wr(8'hDC, v[63:32]);
		rd(8'hDC, {23'h00_0000, v[40:32]});
		wr(8'hD8, v[31:0]);
		rd(8'hD8, v[31:0]);
		wr(8'h10, v[31:0]);
		rd(8'h10, 32'h0000_0000);
		for (int i = 0; i < 32; i++) begin
			v = {$urandom(), $urandom()};
			v[2:0] = {i[1:0], i[2]};
			v[14:3] = 12'h000;
			if (!i[3]) v[40:28] = 13'h0000;
			if (i[4]) v[27:22] = 6'h00;
			wr(8'hD8, 32'h0000_0000);
			wr(8'hDC, v[63:32]);
			wr(8'hD8, v[31:0]);
			repeat (6) @(posedge clk_in);
			#1;
			cmp("outputs", {30'h0, expect_out(v)}, {30'h0, read_block_out, throttle_active_out});
		end
		// Repeated block and release per monitor window
		wr(8'hD8, 32'h0000_0000);
		wr(8'hDC, 32'h0000_0000);
		wr(8'hD8, {4'h0, 6'h01, 7'h01, 12'h002, SEL_COUNTER, 1'b1});
		await_block(1'b1);
		await_block(1'b0);
		await_block(1'b1);
		wr(8'hD8, {4'h0, 6'h01, 7'h01, 12'h002, SEL_COUNTER, 1'b0});
		repeat (3) @(posedge clk_in);
		#1;
		cmp("outputs", 32'h0000_0000, {30'h0, read_block_out, throttle_active_out});
		rd(8'hE0, 32'h0000_0000);
		// Active span over duration global windows, restarted a clock later
		for (int j = 1; j <= 3; j++) begin
			wr(8'hD8, 32'h0000_0000);
			@(posedge clk_in);
			gsw <= 32'h0000_0008 + $urandom_range(32);
			wr(8'hD8, {4'h0, 6'(j), 7'h00, 12'h000, SEL_COUNTER, 1'b1});
			measure_active(span, gap);
			cmp("active span", expect_span(j, gsw), span);
			cmp("idle gap", 32'h0000_0001, gap);
		end
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
